// File: dv/phy_status_chk.sv
`timescale 1ns/1ps
module phy_status_chk (
   input wire logic                       clk,
   input wire logic                       rst_n,
   input wire logic [7:0]                 address,
   input wire logic                       read,
   input wire logic                       write,
   input wire logic [3:0]                 byteenable,
   input wire logic [31:0]                writedata,
   input wire logic [31:0]                readdata,
   input wire logic                       waitrequest,
   input wire phy_status_pkg::phy_state_t line_state,
   input wire phy_status_pkg::phy_pulse_t line_pulse,
   input wire logic                       irq,
   input wire logic                       int_pin
);
   // Counts edges over which the line state has stayed put
   logic [2:0]                 scnt;
   phy_status_pkg::phy_state_t prev;
   wire st_rd  = read && !waitrequest && (address[7:2] == phy_status_pkg::STATUS_IDX)
                 && (scnt == 3'h4) && (line_state == prev);
   wire en_rd  = read && !waitrequest && (address[7:2] == phy_status_pkg::ENABLE_IDX);
   wire en_clr = write && !waitrequest && (address[7:2] == phy_status_pkg::ENABLE_IDX)
                 && (writedata[15:0] == 16'h0000) && (byteenable[1:0] == 2'h3);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev <= phy_status_pkg::STATE_RESET;
         scnt <= 3'h0;
      end else begin
         prev <= line_state;
         scnt <= (line_state != prev) ? 3'h0 : ((scnt == 3'h4) ? scnt : scnt + 3'h1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_rate_duplex: assert property (
      st_rd |-> readdata[15:13] == {line_state.rate, line_state.full_duplex})
      else $error("rate or duplex field wrong");
   a_link_xover: assert property (
      st_rd |-> readdata[11:8] == {line_state.neg_resolved, line_state.link_up,
                                   line_state.xover_cd, line_state.xover_ab})
      else $error("link or crossover field wrong");
   a_dshift_sleep: assert property (
      st_rd |-> readdata[7:6] == {line_state.downshift_active, line_state.sleep_active})
      else $error("downshift or sleep field wrong");
   a_chan_pol: assert property (
      st_rd |-> readdata[5:2] == line_state.chan_polarity)
      else $error("channel polarity field wrong");
   a_rx_jabber: assert property (
      st_rd |-> readdata[1:0] == {line_state.rx_polarity_ok, line_state.jabber})
      else $error("rx polarity or jabber field wrong");
   a_reserved_zero: assert property (
      en_rd |-> readdata[9] == 1'b0 && readdata[7] == 1'b0 && readdata[31:16] == 16'h0000)
      else $error("reserved enable bits not zero");
   a_enable_quiet: assert property (
      en_clr |-> ##3 !irq[*2])
      else $error("interrupt with all enables off");
   a_pin_follows: assert property (
      (irq != $past(irq)) |-> (int_pin != $past(int_pin)))
      else $error("interrupt pin did not follow irq");
   a_reset_levels: assert property (
      $rose(rst_n) |-> !irq && int_pin)
      else $error("interrupt levels wrong after reset");
endmodule

bind phy_status_interrupt_enable phy_status_chk u_chk (
   .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
   .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
   .waitrequest(waitrequest), .line_state(line_state), .line_pulse(line_pulse),
   .irq(irq), .int_pin(int_pin)
);

// File: dv/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module tb;
   logic                       clk = 1'b0;
   logic                       rst_n = 1'b0;
   logic [7:0]                 address = 8'h00;
   logic                       read = 1'b0;
   logic                       write = 1'b0;
   logic [31:0]                writedata = 32'h0000_0000;
   logic [3:0]                 be = 4'hF;
   logic [31:0]                readdata;
   logic                       waitrequest;
   logic                       irq;
   logic                       int_pin;
   phy_status_pkg::phy_state_t line_state = phy_status_pkg::STATE_RESET;
   phy_status_pkg::phy_pulse_t line_pulse = '0;
   int                         fails = 0;
   int                         n_tests = 0;
   logic [31:0]                seed = 32'h6E13;
   logic [15:0]                evb [6] = '{16'h0020, 16'h0004, 16'h0008, 16'h0100,
                                           16'h1000, 16'h8000};

   always #4 clk = ~clk;

   phy_status_interrupt_enable u_dut (
      .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
      .byteenable(be), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .line_state(line_state), .line_pulse(line_pulse),
      .irq(irq), .int_pin(int_pin)
   );

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [15:0] exp_status(phy_status_pkg::phy_state_t s, logic pg);
      return {s.rate, s.full_duplex, pg, s.neg_resolved, s.link_up, s.xover_cd,
              s.xover_ab, s.downshift_active, s.sleep_active, s.chan_polarity,
              s.rx_polarity_ok, s.jabber};
   endfunction

   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] wd,
                      output logic [15:0] rd);
      @(posedge clk);
      address   <= a;
      writedata <= {16'h0000, wd};
      write     <= wr;
      read      <= !wr;
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      rd = readdata[15:0];
      read  <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic pulse(input phy_status_pkg::phy_pulse_t p);
      @(posedge clk);
      line_pulse <= p;
      @(posedge clk);
      line_pulse <= '0;
      repeat (3) @(posedge clk);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      report_and_stop();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      int                         i;
      logic [15:0]                rd;
      logic [15:0]                w;
      phy_status_pkg::phy_state_t s;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, 8'h48, 16'h0000, rd);
      `CHK(rd, 16'h0000)
      bus(1'b0, 8'h54, 16'h0000, rd);
      `CHK(rd, 16'h2000)
      bus(1'b0, 8'h44, 16'h0000, rd);
      `CHK(rd, 16'h0002)
      `CHK(int_pin, 1'b1)
      // Random line states, each read twice: nothing but the page bit may clear
      for (i = 0; i < 40; i++) begin
         s = (i == 0) ? 15'h7FFF : 15'(xs());
         @(posedge clk);
         line_state <= s;
         repeat (3) @(posedge clk);
         bus(1'b0, 8'h44, 16'h0000, rd);
         `CHK(rd, exp_status(s, 1'b0))
         bus(1'b0, 8'h44, 16'h0000, rd);
         `CHK(rd, exp_status(s, 1'b0))
      end
      bus(1'b0, 8'h4C, 16'h0000, rd);
      for (i = 0; i < 8; i++) begin
         w = (i == 0) ? 16'hFFFF : 16'(xs());
         bus(1'b1, 8'h48, w, rd);
         bus(1'b0, 8'h48, 16'h0000, rd);
         `CHK(rd, w & 16'hFD7F)
      end
      // Low byte lane only: the upper enables must survive
      bus(1'b1, 8'h48, 16'hFFFF, rd);
      be <= 4'h1;
      bus(1'b1, 8'h48, 16'h0000, rd);
      be <= 4'hF;
      bus(1'b0, 8'h48, 16'h0000, rd);
      `CHK(rd, 16'hFD00)
      bus(1'b1, 8'h48, 16'h0000, rd);
      pulse(6'h10);
      bus(1'b1, 8'h44, 16'hFFFF, rd);
      bus(1'b0, 8'h44, 16'h0000, rd);
      `CHK(rd, exp_status(s, 1'b1))
      bus(1'b0, 8'h44, 16'h0000, rd);
      `CHK(rd[12], 1'b0)
      pulse(6'h04);
      `CHK(irq, 1'b0)
      bus(1'b0, 8'h4C, 16'h0000, rd);
      `CHK(rd, 16'h1008)
      bus(1'b0, 8'h4C, 16'h0000, rd);
      `CHK(rd, 16'h0000)
      // Every strobe raises the interrupt once enabled; the read clears it
      bus(1'b1, 8'h48, 16'hFD7F, rd);
      for (i = 0; i < 6; i++) begin
         pulse(6'h01 << i);
         `CHK({irq, int_pin}, 2'b10)
         bus(1'b0, 8'h4C, 16'h0000, rd);
         `CHK(rd, evb[i])
         repeat (3) @(posedge clk);
         `CHK(irq, 1'b0)
      end
      pulse(6'h02);
      bus(1'b1, 8'h50, 16'h0004, rd);
      repeat (3) @(posedge clk);
      `CHK(irq, 1'b0)
      pulse(6'h04);
      bus(1'b1, 8'h54, 16'h0000, rd);
      repeat (3) @(posedge clk);
      `CHK({irq, int_pin}, 2'b11)
      bus(1'b1, 8'h48, 16'h0000, rd);
      repeat (4) @(posedge clk);
      `CHK({irq, int_pin}, 2'b00)
      bus(1'b0, 8'h4C, 16'h0000, rd);
      `CHK(rd, 16'h0008)
      @(posedge clk);
      line_state.link_up <= ~s.link_up;
      repeat (4) @(posedge clk);
      bus(1'b0, 8'h4C, 16'h0000, rd);
      `CHK(rd, 16'h0400)
      bus(1'b1, 8'h00, 16'hFFFF, rd);
      bus(1'b0, 8'h00, 16'h0000, rd);
      `CHK(rd, 16'h0000)
      bus(1'b0, 8'h50, 16'h0000, rd);
      `CHK(rd, 16'h0000)
      report_and_stop();
   end
endmodule

// File: rtl/event_latch.sv
`timescale 1ns/1ps
module event_latch #(
   parameter int unsigned           W    = 16,
   parameter logic [W-1:0]          MASK = '1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clr,
   output wire logic [W-1:0] flags
);

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         if (MASK[i]) begin : g_live
            logic flag_reg;
            // Set wins over a clear in the same cycle
            always_ff @(posedge clk or negedge rst_n) begin
               if (!rst_n) begin
                  flag_reg <= 1'b0;
               end else if (set[i]) begin
                  flag_reg <= 1'b1;
               end else if (clr[i]) begin
                  flag_reg <= 1'b0;
               end
            end
            assign flags[i] = flag_reg;
         end else begin : g_rsvd
            assign flags[i] = 1'b0;
         end
      end
   endgenerate

endmodule

// File: rtl/phy_status_interrupt_enable.sv
`timescale 1ns/1ps
module phy_status_interrupt_enable (
   input  wire  logic                        clk,
   input  wire  logic                        rst_n,
   // Avalon-MM slave
   input  wire  logic [7:0]                  address,
   input  wire  logic                        read,
   input  wire  logic                        write,
   input  wire  logic [3:0]                  byteenable,
   input  wire  logic [31:0]                 writedata,
   output logic       [31:0]                 readdata,
   output logic                              waitrequest,
   // Transceiver core
   input  wire  phy_status_pkg::phy_state_t  line_state,
   input  wire  phy_status_pkg::phy_pulse_t  line_pulse,
   // Interrupt
   output logic                              irq,
   output logic                              int_pin
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   phy_status_pkg::phy_state_t    state_reg;
   logic                          page_reg;
   logic                          page_next;
   logic [15:0]                   enable_reg;
   logic [15:0]                   enable_next;
   logic [15:0]                   cfg_reg;
   logic [15:0]                   cfg_next;
   logic                          wait_reg;
   logic                          wait_next;
   logic [31:0]                   rdata_reg;
   logic [31:0]                   rdata_next;
   logic                          snap_page_reg;
   logic [15:0]                   snap_pend_reg;
   logic                          irq_reg;
   logic                          irq_next;
   logic                          pin_reg;
   logic                          pin_next;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   wire                           req;
   wire                           sample;
   wire                           accept;
   wire [5:0]                     idx;
   wire                           hit_status;
   wire                           hit_enable;
   wire                           hit_pend;
   wire                           hit_pclr;
   wire                           hit_cfg;
   wire [15:0]                    be_mask;
   wire [15:0]                    wdata;
   wire                           wr_enable;
   wire                           wr_pclr;
   wire                           wr_cfg;
   wire                           rd_status;
   wire                           rd_pend;

   assign req        = read | write;
   // First cycle of a request: snapshot read data, raise answer
   assign sample     = req & wait_reg;
   // Second cycle: the master sees waitrequest low and completes
   assign accept     = req & ~wait_reg;
   assign idx        = address[phy_status_pkg::IDX_LSB +: phy_status_pkg::IDX_W];
   assign hit_status = (idx == phy_status_pkg::STATUS_IDX);
   assign hit_enable = (idx == phy_status_pkg::ENABLE_IDX);
   assign hit_pend   = (idx == phy_status_pkg::PEND_IDX);
   assign hit_pclr   = (idx == phy_status_pkg::PCLR_IDX);
   assign hit_cfg    = (idx == phy_status_pkg::CFG_IDX);
   assign be_mask    = {{8{byteenable[1]}}, {8{byteenable[0]}}};
   assign wdata      = writedata[15:0];
   assign wr_enable  = accept & write & hit_enable;
   assign wr_pclr    = accept & write & hit_pclr;
   assign wr_cfg     = accept & write & hit_cfg;
   assign rd_status  = accept & read & hit_status;
   assign rd_pend    = accept & read & hit_pend;

   ////////////////////////////////////////////////////////////////////////////
   // Event detection

   logic [15:0]                   events;
   logic [15:0]                   pend_clr;
   wire  [15:0]                   pend;

   always_comb begin
      events = phy_status_pkg::WORD_ZERO;
      events[phy_status_pkg::EV_NEG_FAULT]     = line_pulse.neg_fault;
      events[phy_status_pkg::EV_RATE]          = line_state.rate != state_reg.rate;
      events[phy_status_pkg::EV_DUPLEX]        =
         line_state.full_duplex != state_reg.full_duplex;
      events[phy_status_pkg::EV_PAGE]          = line_pulse.page_rx;
      events[phy_status_pkg::EV_NEG_DONE]      =
         line_state.neg_resolved & ~state_reg.neg_resolved;
      events[phy_status_pkg::EV_LINK]          = line_state.link_up != state_reg.link_up;
      events[phy_status_pkg::EV_FALSE_CARRIER] = line_pulse.false_carrier;
      events[phy_status_pkg::EV_XOVER]         =
         (line_state.xover_cd != state_reg.xover_cd) |
         (line_state.xover_ab != state_reg.xover_ab);
      events[phy_status_pkg::EV_DSHIFT]        = line_pulse.downshift;
      events[phy_status_pkg::EV_SLEEP]         =
         line_state.sleep_active != state_reg.sleep_active;
      events[phy_status_pkg::EV_WAKE]          = line_pulse.wake;
      events[phy_status_pkg::EV_MAC_ERR]       = line_pulse.mac_err;
      events[phy_status_pkg::EV_POLARITY]      =
         (line_state.rx_polarity_ok != state_reg.rx_polarity_ok) |
         (line_state.chan_polarity != state_reg.chan_polarity);
      events[phy_status_pkg::EV_JABBER]        = line_state.jabber & ~state_reg.jabber;
   end

   // Read clears only bits that were returned; a write clears ones written
   always_comb begin
      pend_clr = phy_status_pkg::WORD_ZERO;
      if (rd_pend) begin
         pend_clr = snap_pend_reg;
      end else if (wr_pclr) begin
         pend_clr = wdata & be_mask;
      end
   end

   // Pending bits latch whether or not enabled
   event_latch #(
      .W    (phy_status_pkg::DATA_W),
      .MASK (phy_status_pkg::EVENT_MASK)
   ) u_pending (
      .clk   (clk),
      .rst_n (rst_n),
      .set   (events),
      .clr   (pend_clr),
      .flags (pend)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Status word assembly

   logic [15:0]                   status_word;

   always_comb begin
      status_word = phy_status_pkg::WORD_ZERO;
      status_word[phy_status_pkg::RATE_LSB +: phy_status_pkg::RATE_W] =
         state_reg.rate;
      status_word[phy_status_pkg::DUPLEX_BIT]   = state_reg.full_duplex;
      status_word[phy_status_pkg::PAGE_BIT]     = page_reg;
      status_word[phy_status_pkg::RESOLVED_BIT] = state_reg.neg_resolved;
      status_word[phy_status_pkg::LINK_BIT]     = state_reg.link_up;
      status_word[phy_status_pkg::XCD_BIT]      = state_reg.xover_cd;
      status_word[phy_status_pkg::XAB_BIT]      = state_reg.xover_ab;
      status_word[phy_status_pkg::DSHIFT_BIT]   = state_reg.downshift_active;
      status_word[phy_status_pkg::SLEEP_BIT]    = state_reg.sleep_active;
      status_word[phy_status_pkg::CHPOL_LSB +: phy_status_pkg::CHPOL_W] =
         state_reg.chan_polarity;
      status_word[phy_status_pkg::RXPOL_BIT]    = state_reg.rx_polarity_ok;
      status_word[phy_status_pkg::JABBER_BIT]   = state_reg.jabber;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   // Page flag: a new page wins over the clearing read
   always_comb begin
      page_next = page_reg;
      if (line_pulse.page_rx) begin
         page_next = 1'b1;
      end else if (rd_status & snap_page_reg) begin
         page_next = 1'b0;
      end
   end

   // Enable word: byte lanes honoured, reserved bits held at zero
   always_comb begin
      enable_next = enable_reg;
      if (wr_enable) begin
         enable_next = ((enable_reg & ~be_mask) | (wdata & be_mask)) &
                       phy_status_pkg::EVENT_MASK;
      end
   end

   always_comb begin
      cfg_next = cfg_reg;
      if (wr_cfg) begin
         cfg_next = ((cfg_reg & ~be_mask) | (wdata & be_mask)) &
                    phy_status_pkg::CFG_MASK;
      end
   end

   // Status is read-only: no write path exists into it
   always_comb begin
      rdata_next = rdata_reg;
      if (sample) begin
         rdata_next = {phy_status_pkg::RD_PAD, phy_status_pkg::WORD_ZERO};
         if (read) begin
            unique case (1'b1)
               hit_status: rdata_next = {phy_status_pkg::RD_PAD, status_word};
               hit_enable: rdata_next = {phy_status_pkg::RD_PAD, enable_reg};
               hit_pend:   rdata_next = {phy_status_pkg::RD_PAD, pend};
               hit_cfg:    rdata_next = {phy_status_pkg::RD_PAD, cfg_reg};
               default:    rdata_next = {phy_status_pkg::RD_PAD, phy_status_pkg::WORD_ZERO};
            endcase
         end
      end
   end

   assign wait_next = ~sample;

   // Interrupt level and pin polarity
   always_comb begin
      irq_next = |(pend & enable_reg);
      pin_next = cfg_reg[phy_status_pkg::IRQ_POL_BIT] ? ~irq_next : irq_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flip-flops

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= phy_status_pkg::STATE_RESET;
      end else begin
         state_reg <= line_state;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         page_reg      <= 1'b0;
         snap_page_reg <= 1'b0;
         snap_pend_reg <= phy_status_pkg::WORD_ZERO;
      end else begin
         page_reg      <= page_next;
         snap_page_reg <= sample ? page_reg : snap_page_reg;
         snap_pend_reg <= sample ? pend : snap_pend_reg;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         enable_reg <= phy_status_pkg::ENABLE_RESET;
         cfg_reg    <= phy_status_pkg::CFG_RESET;
      end else begin
         enable_reg <= enable_next;
         cfg_reg    <= cfg_next;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_reg  <= 1'b1;
         rdata_reg <= {phy_status_pkg::RD_PAD, phy_status_pkg::WORD_ZERO};
      end else begin
         wait_reg  <= wait_next;
         rdata_reg <= rdata_next;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_reg <= 1'b0;
         pin_reg <= 1'b1;
      end else begin
         irq_reg <= irq_next;
         pin_reg <= pin_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign readdata    = rdata_reg;
   assign waitrequest = wait_reg;
   assign irq         = irq_reg;
   assign int_pin     = pin_reg;

endmodule

// File: rtl/phy_status_pkg.sv
package phy_status_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus geometry
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned IDX_W  = 6;
   localparam int unsigned IDX_LSB = 2;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] STATUS_IDX = 6'h11;
   localparam logic [IDX_W-1:0] ENABLE_IDX = 6'h12;
   localparam logic [IDX_W-1:0] PEND_IDX   = 6'h13;
   localparam logic [IDX_W-1:0] PCLR_IDX   = 6'h14;
   localparam logic [IDX_W-1:0] CFG_IDX    = 6'h15;

   ////////////////////////////////////////////////////////////////////////////
   // Status word fields
   localparam int unsigned RATE_LSB     = 14;
   localparam int unsigned RATE_W       = 2;
   localparam int unsigned DUPLEX_BIT   = 13;
   localparam int unsigned PAGE_BIT     = 12;
   localparam int unsigned RESOLVED_BIT = 11;
   localparam int unsigned LINK_BIT     = 10;
   localparam int unsigned XCD_BIT      = 9;
   localparam int unsigned XAB_BIT      = 8;
   localparam int unsigned DSHIFT_BIT   = 7;
   localparam int unsigned SLEEP_BIT    = 6;
   localparam int unsigned CHPOL_LSB    = 2;
   localparam int unsigned CHPOL_W      = 4;
   localparam int unsigned RXPOL_BIT    = 1;
   localparam int unsigned JABBER_BIT   = 0;

   // Rate codes
   localparam logic [1:0] RATE_10M   = 2'h0;
   localparam logic [1:0] RATE_100M  = 2'h1;
   localparam logic [1:0] RATE_1000M = 2'h2;
   localparam logic [1:0] RATE_RSVD  = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Event bits, shared by enable, pending and clear words
   localparam int unsigned EV_NEG_FAULT     = 15;
   localparam int unsigned EV_RATE          = 14;
   localparam int unsigned EV_DUPLEX        = 13;
   localparam int unsigned EV_PAGE          = 12;
   localparam int unsigned EV_NEG_DONE      = 11;
   localparam int unsigned EV_LINK          = 10;
   localparam int unsigned EV_FALSE_CARRIER = 8;
   localparam int unsigned EV_XOVER         = 6;
   localparam int unsigned EV_DSHIFT        = 5;
   localparam int unsigned EV_SLEEP         = 4;
   localparam int unsigned EV_WAKE          = 3;
   localparam int unsigned EV_MAC_ERR       = 2;
   localparam int unsigned EV_POLARITY      = 1;
   localparam int unsigned EV_JABBER        = 0;

   localparam logic [DATA_W-1:0] EVENT_MASK = 16'hFD7F;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values, interrupt polarity bit, config mask and zero words
   localparam logic [DATA_W-1:0] ENABLE_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] CFG_RESET    = 16'h2000;
   localparam int unsigned       IRQ_POL_BIT  = 13;
   localparam logic [DATA_W-1:0] CFG_MASK     = 16'h2000;
   localparam logic [15:0]       RD_PAD       = 16'h0000;
   localparam logic [DATA_W-1:0] WORD_ZERO    = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // Resolved line state from the transceiver core
   typedef struct packed {
      logic [1:0] rate;
      logic       full_duplex;
      logic       neg_resolved;
      logic       link_up;
      logic       xover_cd;
      logic       xover_ab;
      logic       downshift_active;
      logic       sleep_active;
      logic [3:0] chan_polarity;
      logic       rx_polarity_ok;
      logic       jabber;
   } phy_state_t;

   localparam phy_state_t STATE_RESET = 15'h0002;

   // One-cycle event strobes from the transceiver core
   typedef struct packed {
      logic neg_fault;
      logic page_rx;
      logic false_carrier;
      logic wake;
      logic mac_err;
      logic downshift;
   } phy_pulse_t;

endpackage
